/* rtl/fct_regs.vh */
// register offsets, field positions and reset values for the flash charge block
`ifndef FCT_REGS_VH
`define FCT_REGS_VH
`define FCT_CTRL_OFS      12'h000
`define FCT_STAT_OFS      12'h004
`define FCT_IRQ_OFS       12'h008
`define FCT_MASK_OFS      12'h00C
`define FCT_CTRL_MODE_BIT 0
`define FCT_CTRL_RESET    1'h0
`define FCT_MASK_RESET    4'h0
`define FCT_EV_DONE_BIT   0
`define FCT_EV_RECH_BIT   1
`define FCT_EV_FIRE_BIT   2
`define FCT_EV_BLOCK_BIT  3
`define FCT_EV_WIDTH      4
`define FCT_ST_SW_BIT     0
`define FCT_ST_DONE_BIT   1
`define FCT_ST_GATE_BIT   2
`define FCT_ST_STATE_LSB  4
`define FCT_ST_STATE_MSB  8
`endif

/* rtl/fct_sync.v */
// two flip-flop synchroniser for a bus of pin inputs
module fct_sync #(
	parameter W = 1
) (
	input  wire         clk,
	input  wire         reset_n,
	input  wire         clk_en,
	input  wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] s1_r;
	reg [W-1:0] s2_r;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s1_r <= {W{1'b0}};
			s2_r <= {W{1'b0}};
		end else if (clk_en) begin
			s1_r <= d;
			s2_r <= s1_r;
		end
	end

	assign q = s2_r;
endmodule // fct_sync

/* rtl/fct_ctrl.v */
// flash charger control with trigger interlock and apb registers
//
// Local design decisions: register access over APB and the register offsets.
`include "fct_regs.vh"

// Function
// RULE1 - gate request is AND of both fire inputs
// RULE2 - first charge locks gate and ignores fires
// RULE3 - idle regulation fire: gate, recharge after release
// RULE4 - refresh fire: finish cycle, gate, resume later
// RULE5 - request low: gate always enabled
// RULE6 - request high wakes and starts charging
// RULE7 - done low only when requested and on target
// RULE8 - below regulation threshold restarts a charge
// RULE9 - request low stops charging, enters standby
// RULE10 - target comparator terminates charging
// RULE11 - regulation off: recharge needs request toggle
// RULE12 - voltage monitoring active while request high
// RULE13 - droop mode restarts at lower threshold
// RULE14 - direct mode alternates charge and wait
// RULE15 - done released while charging or request low
// RULE16 - all pin inputs synchronised twice; cycle_end is used unsynchronised
// RULE17 - reset into standby, switching off, done released
module fct_ctrl (
	input  wire        clk,
	input  wire        reset_n,
	input  wire        clk_en,
	input  wire        charge_req,
	input  wire        fire_input_a,
	input  wire        fire_input_b,
	input  wire        target_reached,
	input  wire        reg_below,
	input  wire        reg_disabled,
	input  wire        cycle_end,
	output reg         switch_enable,
	output wire        done_o,
	output wire        done_oe_n,
	output reg         flash_gate_driver,
	output reg         gate_enabled,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	output wire        irq
);
	localparam [4:0] ST_STBY  = 5'b00001;
	localparam [4:0] ST_FIRST = 5'b00010;
	localparam [4:0] ST_WAIT  = 5'b00100;
	localparam [4:0] ST_REFR  = 5'b01000;
	localparam [4:0] ST_HOLD  = 5'b10000;

	wire [5:0] sync_q;
	wire       req_s;
	wire       fa_s;
	wire       fb_s;
	wire       tgt_s;
	wire       below_s;
	wire       regoff_s;

	// see RULE16
	fct_sync #(.W(6)) u_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.clk_en  (clk_en),
		.d       ({charge_req, fire_input_a, fire_input_b, target_reached, reg_below,
		           reg_disabled}),
		.q       (sync_q)
	);
	assign {req_s, fa_s, fb_s, tgt_s, below_s, regoff_s} = sync_q;

	reg  [4:0] state_r;
	reg  [4:0] state_nxt;
	reg        done_r;
	reg        ctrl_mode_r;
	reg  [`FCT_EV_WIDTH-1:0] irq_stat_r;
	reg  [`FCT_EV_WIDTH-1:0] irq_mask_r;
	reg  [`FCT_EV_WIDTH-1:0] ev;
	wire       fire = fa_s & fb_s; // see RULE1
	reg        tgt_d_r;
	// comparator still shows the last trip as a refresh starts; only a fresh rise ends a charge
	wire       tgt_rise = tgt_s & ~tgt_d_r; // see RULE10
	wire       regen = ~regoff_s & ~ctrl_mode_r;
	wire       done_nxt;
	wire       sw_nxt;
	wire       gate_nxt;

	// next state of the charge sequencer
	always @* begin
		state_nxt = state_r;
		if (!req_s) begin
			state_nxt = ST_STBY; // see RULE9
		end else begin
			case (state_r)
				ST_STBY: begin
					state_nxt = ST_FIRST; // see RULE6
				end
				ST_FIRST: begin
					if (tgt_rise)
						state_nxt = ST_WAIT; // see RULE10
				end
				ST_WAIT: begin
					if (fire)
						state_nxt = ST_HOLD; // see RULE3
					else if (regen && below_s)
						state_nxt = ST_REFR; // see RULE8 see RULE13 see RULE14 see RULE11
				end
				ST_REFR: begin
					if (fire && cycle_end)
						state_nxt = ST_HOLD; // see RULE4
					else if (tgt_rise)
						state_nxt = ST_WAIT; // see RULE14 see RULE12
				end
				ST_HOLD: begin
					if (!fire)
						state_nxt = tgt_s ? ST_WAIT : ST_REFR; // see RULE3 see RULE4
				end
				default: begin
					state_nxt = ST_STBY;
				end
			endcase
		end
	end

	// done only in steady waiting or a fire hold while on target
	assign done_nxt = req_s & tgt_s &
	                  ((state_nxt == ST_WAIT) || (state_nxt == ST_HOLD)); // see RULE7 see RULE15
	assign sw_nxt = (state_nxt == ST_FIRST) || (state_nxt == ST_REFR);
	// gate locked during first charge and refresh; a refresh fire opens it once the cycle ends
	assign gate_nxt = (state_nxt == ST_STBY) || (state_nxt == ST_WAIT) ||
	                  (state_nxt == ST_HOLD); // see RULE2 see RULE5

	always @* begin
		ev = {`FCT_EV_WIDTH{1'b0}};
		ev[`FCT_EV_DONE_BIT]  = done_nxt & ~done_r;
		ev[`FCT_EV_RECH_BIT]  = (state_nxt == ST_REFR) && (state_r == ST_WAIT);
		ev[`FCT_EV_FIRE_BIT]  = gate_nxt & fire & ~flash_gate_driver;
		ev[`FCT_EV_BLOCK_BIT] = fire & (state_r == ST_FIRST);
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r           <= ST_STBY; // see RULE17
			switch_enable     <= 1'b0;
			done_r            <= 1'b0;
			gate_enabled      <= 1'b1;
			flash_gate_driver <= 1'b0;
			tgt_d_r           <= 1'b0;
		end else if (clk_en) begin
			state_r           <= state_nxt;
			switch_enable     <= sw_nxt;
			done_r            <= done_nxt;
			gate_enabled      <= gate_nxt;
			flash_gate_driver <= gate_nxt & fire; // see RULE1 see RULE2
			tgt_d_r           <= tgt_s;
		end
	end

	// open drain flag: pulled low while done
	assign done_o    = 1'b0;
	assign done_oe_n = ~done_r; // see RULE7 see RULE15

	// apb slave, zero wait states
	wire       wr_acc = psel & penable & pwrite;
	wire       rd_acc = psel & penable & ~pwrite;
	wire       hit_ir = rd_acc && (paddr == `FCT_IRQ_OFS);
	// a read clears only the bits it returned, so an event at the setup edge survives
	wire [`FCT_EV_WIDTH-1:0] rd_clr = hit_ir ? prdata[`FCT_EV_WIDTH-1:0] :
	                                           {`FCT_EV_WIDTH{1'b0}};
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign irq     = |(irq_stat_r & irq_mask_r);

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_mode_r <= `FCT_CTRL_RESET;
			irq_mask_r  <= `FCT_MASK_RESET;
			irq_stat_r  <= {`FCT_EV_WIDTH{1'b0}};
			prdata      <= 32'h00000000;
		end else if (clk_en) begin
			if (wr_acc && paddr == `FCT_CTRL_OFS)
				ctrl_mode_r <= pwdata[`FCT_CTRL_MODE_BIT];
			if (wr_acc && paddr == `FCT_MASK_OFS)
				irq_mask_r <= pwdata[`FCT_EV_WIDTH-1:0];
			// set wins over read clear
			irq_stat_r <= (irq_stat_r & ~rd_clr) | ev;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					`FCT_CTRL_OFS: prdata <= {31'h00000000, ctrl_mode_r};
					`FCT_STAT_OFS: prdata <= {23'h000000, state_r, 1'b0, gate_enabled,
					                          done_r, switch_enable};
					`FCT_IRQ_OFS:  prdata <= {28'h0000000, irq_stat_r};
					`FCT_MASK_OFS: prdata <= {28'h0000000, irq_mask_r};
					default:       prdata <= 32'h00000000;
				endcase
			end
		end
	end
endmodule // fct_ctrl

/* tb/fct_conv_model.sv */
// converter model: trip comparator and switching cycle ends
module fct_conv_model (
	input  wire logic clk,
	input  wire logic charge_req,
	input  wire logic switch_enable,
	output logic      target_reached = 1'b0,
	output logic      cycle_end = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_r = 4'h0;
	logic       sw_d_r = 1'b0;
	always @(posedge clk) begin
		sw_d_r <= switch_enable;
		cnt_r <= switch_enable ? cnt_r + 4'h1 : 4'h0;
		cycle_end <= switch_enable && cnt_r[1:0] == 2'h3;
		// trip level drops when the request falls or a new switching burst starts, not on counter wrap
		if (!charge_req || (switch_enable && !sw_d_r))
			target_reached <= 1'b0;
		else if (cnt_r == 4'hE)
			target_reached <= 1'b1;
	end
endmodule // fct_conv_model

/* tb/fct_ctrl_sva.sv */
// port checker for the flash charge controller
module fct_ctrl_chk (
	input wire clk,
	input wire reset_n,
	input wire charge_req,
	input wire fire_input_a,
	input wire fire_input_b,
	input wire target_reached,
	input wire switch_enable,
	input wire done_o,
	input wire done_oe_n,
	input wire flash_gate_driver,
	input wire gate_enabled
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	fire_and_a: assert property (flash_gate_driver |-> $past(fire_input_a && fire_input_b, 3))
		else $error("drive without both fires");
	gate_lock_a: assert property (!gate_enabled |-> !flash_gate_driver)
		else $error("drive while locked");
	lock_wake_a: assert property ($rose(charge_req) |-> ##3 !gate_enabled)
		else $error("gate open in first charge");
	stby_fire_a: assert property (!$past(charge_req, 3) && !$past(charge_req, 4)
		|-> flash_gate_driver == $past(fire_input_a && fire_input_b, 3))
		else $error("standby drive wrong");
	stby_gate_a: assert property (!$past(charge_req, 3) && !$past(charge_req, 4)
		|-> gate_enabled && !switch_enable) else $error("standby wrong");
	wake_a: assert property ($rose(charge_req) |-> ##[1:4] switch_enable)
		else $error("no wake");
	trip_stop_a: assert property ($rose(target_reached) && switch_enable
		|-> ##[1:4] !switch_enable) else $error("no stop at trip");
	done_req_a: assert property (!done_oe_n |-> $past(charge_req, 3))
		else $error("done without request");
	done_sw_a: assert property (!done_oe_n |-> !switch_enable)
		else $error("done while charging");
	od_low_a: assert property (done_o == 1'b0)
		else $error("flag drives high");
endmodule // fct_ctrl_chk

/* tb/testbench.sv */
// flash charge controller testbench
`include "fct_regs.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, reset_n = 0, req = 0, fa = 0, fb = 0, rb = 0, rd = 0, en = 1;
	logic        psel = 0, penable = 0, pwrite = 0, sw, doe, drv, gen, tr, ce, irq;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	int          n_errors = 0, n_compared = 0, i;
	fct_ctrl dut (.clk(clk), .reset_n(reset_n), .clk_en(en), .charge_req(req),
		.fire_input_a(fa), .fire_input_b(fb), .target_reached(tr), .reg_below(rb),
		.reg_disabled(rd), .cycle_end(ce), .switch_enable(sw), .done_o(), .done_oe_n(doe),
		.flash_gate_driver(drv), .gate_enabled(gen), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(),
		.pslverr(), .irq(irq));
	fct_conv_model cm (.clk(clk), .charge_req(req), .switch_enable(sw),
		.target_reached(tr), .cycle_end(ce));
	initial forever #2.5 clk = ~clk;
	task chk(input logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task cy(input int n);
		repeat (n) @(posedge clk);
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk) penable <= 1;
		do @(posedge clk); while (dut.pready !== 1'b1);
		r = prdata;
		psel <= 0;
		penable <= 0;
	endtask
	task stop_test;
		$display("compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#30000;
		n_errors++;
		stop_test;
	end
	initial begin
		cy(16);
		reset_n <= 1;
		cy(2);
		chk({sw, doe, gen, drv}, 4'h6);
		fa <= 1;
		cy(5);
		chk(drv, 0);
		fb <= 1;
		cy(5);
		chk(drv, 1);
		fa <= 0;
		fb <= 0;
		apb(1, `FCT_MASK_OFS, 32'h1);
		req <= 1;
		fa <= 1;
		fb <= 1;
		cy(6);
		chk({sw, gen, drv}, 3'h4);
		fa <= 0;
		fb <= 0;
		for (i = 0; i < 60 && doe !== 0; i++) cy(1);
		chk({doe, sw, gen, irq}, 4'h3);
		apb(0, `FCT_IRQ_OFS, 0);
		chk(r[0], 1);
		cy(2);
		chk(irq, 0);
		apb(0, 12'h010, 0);
		chk(r, 0);
		$display("charge test done");
		fa <= 1;
		fb <= 1;
		cy(6);
		chk({drv, sw}, 2'h2);
		fa <= 0;
		fb <= 0;
		cy(5);
		rb <= 1;
		cy(5);
		chk({sw, doe, gen}, 3'h6);
		rb <= 0;
		fa <= 1;
		fb <= 1;
		for (i = 0; i < 20 && drv !== 1; i++) cy(1);
		chk({drv, sw}, 2'h2);
		fa <= 0;
		fb <= 0;
		for (i = 0; i < 60 && doe !== 0; i++) cy(1);
		chk(doe, 0);
		apb(1, `FCT_CTRL_OFS, 32'h1);
		rb <= 1;
		cy(10);
		chk(sw, 0);
		apb(0, `FCT_CTRL_OFS, 0);
		chk(r, 1);
		rd <= 1;
		cy(1);
		apb(1, `FCT_CTRL_OFS, 0);
		cy(10);
		chk(sw, 0);
		en <= 0;
		fa <= 1;
		fb <= 1;
		cy(5);
		chk({drv, doe, sw}, 3'h0);
		en <= 1;
		cy(5);
		chk({drv, gen}, 2'h3);
		fa <= 0;
		fb <= 0;
		cy(5);
		req <= 0;
		cy(5);
		chk({sw, doe, gen}, 3'h3);
		$display("regulation test done");
		stop_test;
	end
endmodule // testbench
bind fct_ctrl fct_ctrl_chk chk_i (.clk(clk), .reset_n(reset_n), .charge_req(charge_req),
	.fire_input_a(fire_input_a), .fire_input_b(fire_input_b), .target_reached(target_reached),
	.switch_enable(switch_enable), .done_o(done_o), .done_oe_n(done_oe_n),
	.flash_gate_driver(flash_gate_driver), .gate_enabled(gate_enabled));
